// file: shared/eeprom_link_pkg.sv
// shared constants for the serial eeprom bus front end and its master
// assumes a single 10 MHz clock on both ends
package eeprom_link_pkg;
    // ------------------------------------------------------------
    // select byte layout
    // ------------------------------------------------------------
    localparam logic [3:0] type_array     = 4'ha;
    localparam logic [3:0] type_id_page   = 4'hb;
    localparam int         sel_type_msb   = 7;
    localparam int         sel_type_lsb   = 4;
    localparam int         sel_strap_bit  = 3;
    localparam int         sel_addr9_bit  = 2;
    localparam int         sel_addr8_bit  = 1;
    localparam int         sel_rw_bit     = 0;
    // ------------------------------------------------------------
    // address byte layout and array geometry
    // ------------------------------------------------------------
    localparam int         id_lock_bit    = 7;
    localparam int         id_loc_msb     = 3;
    localparam int         array_bytes    = 1024;
    localparam int         array_pages    = 64;
    localparam int         page_bytes     = 16;
    localparam int         addr_w         = 10;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int         clk_period_ns  = 100;
    localparam int         scl_period_ns  = 10000;
    localparam int         scl_half_cyc   = scl_period_ns / (2 * clk_period_ns);
    localparam int         glitch_cyc     = 2;
    localparam int         bits_per_byte  = 8;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] byte_rst       = 8'h00;
    localparam logic [3:0] count_rst      = 4'h0;
endpackage

// file: shared/eeprom_link_if.sv
// two-wire bus between master and eeprom front end
// sda is the wired-and of both open-drain drivers, scl is driven by the master alone; pull-up when nobody drives
`timescale 1ns/100ps
interface eeprom_link_if;
    logic scl_out_m;
    logic scl_oe_n_m;
    logic sda_out_m;
    logic sda_oe_n_m;
    logic sda_out_s;
    logic sda_oe_n_s;
    logic scl;
    logic sda;

    assign scl = scl_oe_n_m ? 1'b1 : scl_out_m;
    assign sda = (sda_oe_n_m ? 1'b1 : sda_out_m) & (sda_oe_n_s ? 1'b1 : sda_out_s);

    modport master (output scl_out_m, output scl_oe_n_m, output sda_out_m,
                    output sda_oe_n_m, input scl, input sda);
    modport device (output sda_out_s, output sda_oe_n_s, input scl, input sda);
endinterface

// file: hdl/eeprom_fifo.sv
// small valid/ready fifo for byte streams
// assumes one clock, asynchronous active-low reset
`timescale 1ns/100ps
module eeprom_fifo #(
    parameter int width = 8,
    parameter int depth = 32
) (
    input  wire logic             mclk,
    input  wire logic             resetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [width-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [width-1:0] out_data
);
    localparam int aw = $clog2(depth);
    logic [width-1:0] mem [depth];
    logic [aw-1:0]    wr_q;
    logic [aw-1:0]    rd_q;
    logic [aw:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != (aw+1)'(depth));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == aw'(depth-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == aw'(depth-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (aw+1)'(push) - (aw+1)'(pop);
        end
    end
endmodule // eeprom_fifo

// file: hdl/eeprom_front.sv
// eeprom bus front end: start/stop, select and address decode, acknowledge
// assumes scl and sda arrive asynchronously; write engine reports busy
// Contract
// - falling sda with scl high starts transaction
// - master sends start before any instruction
// - watch for start except while writing
// - rising sda with scl high ends transaction
// - stop after write data launches write
// - capture sda on each scl rise
// - master changes sda only while scl low
// - release after eight bits, ack ninth
// - msb first; type 1010 array, 1011 id
// - select bit three must match strap
// - floating strap reads as zero
// - last select bit: one read, zero write
// - array: b2 b1 are top address bits
// - id page ignores b2 and b1
// - mismatch: release bus, standby until start
// - match: ack ninth period, expect address; a matching read select goes to st_read and takes no address
// - acknowledge the address byte
// - array 1024 bytes, ten address bits
// - id: b7 zero data, one lock
// - protect high blocks array writes
// - protected: ack select, address; not data
// - sda only pulled low or released
// - busy: sda released, requests ignored
`timescale 1ns/100ps
module eeprom_front #(
    parameter int glitch = eeprom_link_pkg::glitch_cyc,
    parameter int depth  = 32
) (
    input  wire logic        mclk,
    input  wire logic        resetn,
    eeprom_link_if.device    link,
    input  wire logic        chip_enable_strap,
    input  wire logic        write_protect_input,
    input  wire logic        write_busy,
    output logic             write_launch_q,
    output logic             id_page_q,
    output logic             lock_req_q,
    output logic             read_req_q,
    output logic [9:0]       addr_q,
    output logic             data_valid,
    input  wire logic        data_ready,
    output logic [7:0]       data_out
);
    typedef enum {st_idle, st_sel, st_addr, st_data, st_read, st_standby} state_t;
    state_t     state_q;
    logic [1:0] scl_s_q;
    logic [1:0] sda_s_q;
    logic [3:0] scl_cnt_q;
    logic [3:0] sda_cnt_q;
    logic       scl_f_q;
    logic       sda_f_q;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic [7:0] shift_q;
    logic [3:0] bit_q;
    logic       ack_slot_q;
    logic       ack_drv_q;
    logic       wrote_q;
    logic       ack_ok_d;
    logic [7:0] sel;
    logic       fifo_in_ready;
    logic       push_q;
    logic [1:0] strap_s_q;
    logic [1:0] wp_s_q;

    // ------------------------------------------------------------
    // sync and deglitch
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            scl_s_q   <= 2'h3;
            sda_s_q   <= 2'h3;
            scl_cnt_q <= eeprom_link_pkg::count_rst;
            sda_cnt_q <= eeprom_link_pkg::count_rst;
            scl_f_q   <= 1'b1;
            sda_f_q   <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[0], link.scl};
            sda_s_q <= {sda_s_q[0], link.sda};
            if (scl_s_q[1] == scl_f_q) begin
                scl_cnt_q <= '0;
            end else if (scl_cnt_q == 4'(glitch)) begin
                scl_f_q   <= scl_s_q[1];
                scl_cnt_q <= '0;
            end else begin
                scl_cnt_q <= scl_cnt_q + 4'h1;
            end
            if (sda_s_q[1] == sda_f_q) begin
                sda_cnt_q <= '0;
            end else if (sda_cnt_q == 4'(glitch)) begin
                sda_f_q   <= sda_s_q[1];
                sda_cnt_q <= '0;
            end else begin
                sda_cnt_q <= sda_cnt_q + 4'h1;
            end
        end
    end

    assign scl_rise  = scl_s_q[1] && !scl_f_q && (scl_cnt_q == 4'(glitch));
    assign scl_fall  = !scl_s_q[1] && scl_f_q && (scl_cnt_q == 4'(glitch));
    assign start_det = scl_f_q && sda_f_q && !sda_s_q[1]
                       && (sda_cnt_q == 4'(glitch)) && !write_busy;
    assign stop_det  = scl_f_q && !sda_f_q && sda_s_q[1] && (sda_cnt_q == 4'(glitch));
    assign sel       = shift_q;

    // ------------------------------------------------------------
    // strap and protect synchronised, floating read as zero
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            strap_s_q <= 2'h0;
            wp_s_q    <= 2'h0;
        end else begin
            strap_s_q <= {strap_s_q[0], (chip_enable_strap === 1'b1)};
            wp_s_q    <= {wp_s_q[0], (write_protect_input === 1'b1)};
        end
    end

    // ------------------------------------------------------------
    // acknowledge decision for the byte just shifted in
    // ------------------------------------------------------------
    always_comb begin
        ack_ok_d = 1'b0;
        if (state_q == st_sel) begin
            ack_ok_d = (sel[7:4] == eeprom_link_pkg::type_array
                        || sel[7:4] == eeprom_link_pkg::type_id_page)
                       && (sel[eeprom_link_pkg::sel_strap_bit] == strap_s_q[1]);
        end else if (state_q == st_addr) begin
            ack_ok_d = 1'b1;
        end else if (state_q == st_data) begin
            ack_ok_d = !wp_s_q[1] && fifo_in_ready;
        end
    end

    // ------------------------------------------------------------
    // byte engine
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q        <= st_idle;
            shift_q        <= eeprom_link_pkg::byte_rst;
            bit_q          <= eeprom_link_pkg::count_rst;
            ack_slot_q     <= 1'b0;
            ack_drv_q      <= 1'b0;
            wrote_q        <= 1'b0;
            write_launch_q <= 1'b0;
            id_page_q      <= 1'b0;
            lock_req_q     <= 1'b0;
            read_req_q     <= 1'b0;
            addr_q         <= '0;
            push_q         <= 1'b0;
        end else begin
            write_launch_q <= 1'b0;
            push_q         <= 1'b0;
            if (write_busy) begin
                state_q   <= st_idle;
                ack_drv_q <= 1'b0;
            end else if (start_det) begin
                state_q    <= st_sel;
                bit_q      <= '0;
                ack_slot_q <= 1'b0;
                ack_drv_q  <= 1'b0;
                wrote_q    <= 1'b0;
            end else if (stop_det) begin
                write_launch_q <= wrote_q && !ack_slot_q;
                wrote_q        <= 1'b0;
                state_q        <= st_idle;
                ack_drv_q      <= 1'b0;
            end else if (scl_rise && !ack_slot_q
                         && state_q != st_idle && state_q != st_standby) begin
                shift_q <= {shift_q[6:0], sda_f_q};
                bit_q   <= bit_q + 4'h1;
            end else if (scl_fall && ack_slot_q) begin
                ack_slot_q <= 1'b0;
                ack_drv_q  <= 1'b0;
                bit_q      <= '0;
            end else if (scl_fall && bit_q == 4'(eeprom_link_pkg::bits_per_byte)
                         && state_q != st_read) begin
                ack_slot_q <= 1'b1;
                ack_drv_q  <= ack_ok_d;
                if (state_q == st_sel) begin
                    if (!ack_ok_d) begin
                        state_q <= st_standby;
                    end else begin
                        id_page_q  <= (sel[4] == 1'b1);
                        read_req_q <= sel[eeprom_link_pkg::sel_rw_bit];
                        if (sel[4] == 1'b0) begin
                            addr_q[9:8] <= sel[2:1];
                        end
                        state_q <= sel[eeprom_link_pkg::sel_rw_bit] ? st_read : st_addr;
                    end
                end else if (state_q == st_addr) begin
                    lock_req_q <= id_page_q && shift_q[eeprom_link_pkg::id_lock_bit];
                    if (id_page_q) begin
                        addr_q <= {6'h00, shift_q[3:0]};
                    end else begin
                        addr_q[7:0] <= shift_q;
                    end
                    state_q <= st_data;
                end else if (state_q == st_data) begin
                    if (ack_ok_d || id_page_q) begin
                        wrote_q <= 1'b1;
                        push_q  <= 1'b1;
                    end
                end
            end else if (scl_fall && state_q == st_read && bit_q == 4'h1) begin
                bit_q <= '0; // read data path lies outside this front end
            end
        end
    end

    // ------------------------------------------------------------
    // open-drain sda: pull low or release only
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            link.sda_out_s  <= 1'b0;
            link.sda_oe_n_s <= 1'b1;
        end else begin
            link.sda_out_s  <= 1'b0;
            link.sda_oe_n_s <= !(ack_drv_q && !write_busy);
        end
    end

    eeprom_fifo #(.width(8), .depth(depth)) u_fifo (
        .mclk      (mclk),
        .resetn    (resetn),
        .in_valid  (push_q),
        .in_ready  (fifo_in_ready),
        .in_data   (shift_q),
        .out_valid (data_valid),
        .out_ready (data_ready),
        .out_data  (data_out)
    );
endmodule // eeprom_front

// file: hdl/eeprom_master.sv
// bus master for the eeprom front end: start, bytes out, ack check, stop
// assumes one clock; scl made by a divider and driven open-drain
`timescale 1ns/100ps
module eeprom_master #(
    parameter int half = eeprom_link_pkg::scl_half_cyc
) (
    input  wire logic       mclk,
    input  wire logic       resetn,
    eeprom_link_if.master   link,
    input  wire logic       cmd_valid,
    output logic            cmd_ready,
    input  wire logic [7:0] cmd_byte,
    input  wire logic       cmd_start,
    input  wire logic       cmd_stop,
    output logic            ack_valid_q,
    output logic            ack_seen_q,
    output logic            busy_q
);
    typedef enum {m_idle, m_start, m_bits, m_ack, m_stop} mstate_t;
    mstate_t    st_q;
    logic [7:0] div_q;
    logic       tick;
    logic       mid;
    logic       phase_q;
    logic [7:0] sh_q;
    logic [3:0] n_q;
    logic       stop_q;
    logic [1:0] sda_s_q;
    logic       cmd_q;

    assign tick      = (div_q == 8'(half - 1));
    assign mid       = (div_q == 8'(half / 2 - 1));
    assign cmd_ready = (st_q == m_idle) && !cmd_q;
    assign busy_q    = cmd_q;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            div_q   <= '0;
            sda_s_q <= 2'h3;
        end else begin
            div_q   <= tick ? '0 : div_q + 8'h01;
            sda_s_q <= {sda_s_q[0], link.sda};
        end
    end

    // master changes sda while scl high only for start and stop
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_q            <= m_idle;
            phase_q         <= 1'b0;
            sh_q            <= eeprom_link_pkg::byte_rst;
            n_q             <= eeprom_link_pkg::count_rst;
            stop_q          <= 1'b0;
            cmd_q           <= 1'b0;
            ack_valid_q     <= 1'b0;
            ack_seen_q      <= 1'b0;
            link.scl_out_m  <= 1'b0;
            link.scl_oe_n_m <= 1'b1;
            link.sda_out_m  <= 1'b0;
            link.sda_oe_n_m <= 1'b1;
        end else begin
            ack_valid_q <= 1'b0;
            if (st_q == m_idle && cmd_valid && !cmd_q) begin
                sh_q   <= cmd_byte;
                stop_q <= cmd_stop;
                cmd_q  <= 1'b1;
                n_q    <= '0;
                phase_q <= 1'b0;
                st_q   <= cmd_start ? m_start : m_bits;
            end else if (tick) begin
                phase_q <= !phase_q;
                case (st_q)
                    m_start: begin
                        if (!phase_q) begin
                            link.sda_oe_n_m <= 1'b1;
                            link.scl_oe_n_m <= 1'b1;
                        end else begin
                            link.sda_oe_n_m <= 1'b0;
                            st_q            <= m_bits;
                        end
                    end
                    m_bits: begin
                        if (!phase_q) begin
                            link.scl_oe_n_m <= 1'b0;
                        end else begin
                            link.scl_oe_n_m <= 1'b1;
                            sh_q            <= {sh_q[6:0], 1'b0};
                            n_q             <= n_q + 4'h1;
                            if (n_q == 4'(eeprom_link_pkg::bits_per_byte - 1)) begin
                                st_q <= m_ack;
                            end
                        end
                    end
                    m_ack: begin
                        if (!phase_q) begin
                            link.scl_oe_n_m <= 1'b0;
                        end else begin
                            link.scl_oe_n_m <= 1'b1;
                        end
                        if (phase_q && n_q == 4'(eeprom_link_pkg::bits_per_byte)) begin
                            n_q <= n_q + 4'h1;
                        end else if (!phase_q && n_q == 4'(eeprom_link_pkg::bits_per_byte + 1)) begin
                            ack_valid_q <= 1'b1;
                            ack_seen_q  <= !sda_s_q[1];
                            st_q        <= stop_q ? m_stop : m_idle;
                            cmd_q       <= stop_q;
                        end
                    end
                    m_stop: begin
                        if (!link.scl_oe_n_m) begin
                            link.scl_oe_n_m <= 1'b1;
                        end else begin
                            link.sda_oe_n_m <= 1'b1;
                            st_q            <= m_idle;
                            cmd_q           <= 1'b0;
                        end
                    end
                    default: begin
                        st_q <= m_idle;
                    end
                endcase
            end else if (st_q == m_idle) begin
                cmd_q <= 1'b0;
            end else if (mid && phase_q) begin
                if (st_q == m_bits) begin
                    link.sda_oe_n_m <= sh_q[7];
                end else if (st_q == m_ack) begin
                    link.sda_oe_n_m <= 1'b1;
                end else if (st_q == m_stop && !link.scl_oe_n_m) begin
                    link.sda_oe_n_m <= 1'b0;
                end
            end
        end
    end
endmodule // eeprom_master

// file: tb/eeprom_link_properties.sv
// concurrent checks on the two-wire link between master and eeprom front
// assumes mclk samples scl and sda; instantiated beside the link
`timescale 1ns/100ps
module eeprom_link_properties (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic scl_out_m,
    input wire logic scl_oe_n_m,
    input wire logic sda_out_m,
    input wire logic sda_oe_n_m,
    input wire logic sda_out_s,
    input wire logic sda_oe_n_s,
    input wire logic scl,
    input wire logic sda
);
    logic       scl_q;
    logic       sda_q;
    logic [3:0] pulse_q;
    logic       start;
    logic       stop;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------
    // wire history and scl pulse count since start
    // ------------------------------------------------------------
    assign start = scl && scl_q && sda_q && !sda;
    assign stop  = scl && scl_q && !sda_q && sda;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pulse_q <= 4'h0;
        end else if (start) begin
            pulse_q <= 4'h0;
        end else if (scl && !scl_q) begin
            pulse_q <= (pulse_q == 4'h9) ? 4'h1 : pulse_q + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_ack_ninth_slot: assert property (!sda_oe_n_s |-> (pulse_q == 4'h8 || pulse_q == 4'h9))
        else $error("device drives sda outside the ack slot");
    a_device_low_only: assert property (!sda_oe_n_s |-> !sda_out_s)
        else $error("device drives sda high");
    a_master_sda_low: assert property (!sda_oe_n_m |-> !sda_out_m)
        else $error("master drives sda high");
    a_master_scl_low: assert property (!scl_oe_n_m |-> !scl_out_m)
        else $error("master drives scl high");
    a_ack_take_low: assert property ($fell(sda_oe_n_s) |-> !scl)
        else $error("device takes sda while scl high");
    a_ack_leave_low: assert property ($rose(sda_oe_n_s) |-> !scl)
        else $error("device releases sda while scl high");
    a_ack_steady_high: assert property ((scl && scl_q) |-> $stable(sda_oe_n_s))
        else $error("device sda changes while scl high");
    a_start_quiet: assert property (start |=> sda_oe_n_s [*8])
        else $error("device drives sda right after start");
    a_stop_quiet: assert property (stop |-> sda_oe_n_s)
        else $error("device drives sda at stop");
endmodule // eeprom_link_properties

// file: tb/serial_eeprom_i2c_slave_front_test.sv
// testbench: master and eeprom front joined by the link interface
// assumes 10 MHz mclk; master scl half period shortened to 10 cycles
`timescale 1ns/100ps
module serial_eeprom_i2c_slave_front_test;
    logic       mclk, resetn, cmd_valid, cmd_ready, cmd_start, cmd_stop;
    logic       ack_valid_q, ack_seen_q, busy_q, strap, wp, wbusy;
    logic       write_launch_q, id_page_q, lock_req_q, read_req_q;
    logic       data_valid, data_ready;
    logic [7:0] cmd_byte, data_out;
    logic [9:0] addr_q;
    logic [7:0] bad [3] = '{8'h9a, 8'hca, 8'ha2};
    int         failures = 0;
    int         n_tests = 0;
    int         launches = 0;

    eeprom_link_if link ();
    eeprom_master #(.half(10)) eeprom_master_inst (.mclk(mclk), .resetn(resetn),
        .link(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_byte(cmd_byte),
        .cmd_start(cmd_start), .cmd_stop(cmd_stop), .ack_valid_q(ack_valid_q),
        .ack_seen_q(ack_seen_q), .busy_q(busy_q));
    eeprom_front #(.glitch(2), .depth(32)) eeprom_front_inst (.mclk(mclk),
        .resetn(resetn), .link(link), .chip_enable_strap(strap),
        .write_protect_input(wp), .write_busy(wbusy), .write_launch_q(write_launch_q),
        .id_page_q(id_page_q), .lock_req_q(lock_req_q), .read_req_q(read_req_q),
        .addr_q(addr_q), .data_valid(data_valid), .data_ready(data_ready),
        .data_out(data_out));
    eeprom_link_properties eeprom_link_properties_inst (.mclk(mclk), .resetn(resetn),
        .scl_out_m(link.scl_out_m), .scl_oe_n_m(link.scl_oe_n_m),
        .sda_out_m(link.sda_out_m), .sda_oe_n_m(link.sda_oe_n_m),
        .sda_out_s(link.sda_out_s), .sda_oe_n_s(link.sda_oe_n_s),
        .scl(link.scl), .sda(link.sda));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    always @(posedge mclk) if (write_launch_q === 1'b1) launches++;

    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task finish_test;
        if (failures == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic xfer(input string what, input logic [7:0] b, input logic st,
                        input logic sp, input logic exp);
        int n;
        cmd_byte <= b;
        cmd_start <= st;
        cmd_stop <= sp;
        cmd_valid <= 1'b1;
        n = 0;
        do begin @(posedge mclk); n++; end while (cmd_ready !== 1'b1 && n < 200);
        chk("cmd_ready", 10'h1, {9'h0, cmd_ready});
        cmd_valid <= 1'b0;
        n = 0;
        do begin @(posedge mclk); n++; end while (ack_valid_q !== 1'b1 && n < 400);
        chk("ack_valid", 10'h1, {9'h0, ack_valid_q});
        chk(what, {9'h0, exp}, {9'h0, ack_seen_q});
        n = 0;
        while (sp && busy_q !== 1'b0 && n < 400) begin @(posedge mclk); n++; end
        if (sp) chk("busy_q", 10'h0, {9'h0, busy_q});
        if (sp) repeat (20) @(posedge mclk);
    endtask

    task automatic drain(input logic [7:0] exp);
        int n;
        n = 0;
        while (data_valid !== 1'b1 && n < 100) begin @(posedge mclk); n++; end
        chk("data_valid", 10'h1, {9'h0, data_valid});
        chk("data_out", {2'h0, exp}, {2'h0, data_out});
        data_ready <= 1'b1;
        @(posedge mclk);
        data_ready <= 1'b0;
        @(posedge mclk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_write;
        int l0;
        l0 = launches;
        strap <= 1'b1;
        xfer("sel", 8'haa, 1'b1, 1'b0, 1'b1);
        xfer("addr", 8'h5c, 1'b0, 1'b0, 1'b1);
        chk("addr_q", 10'h15c, addr_q);
        chk("id_page_q", 10'h0, {9'h0, id_page_q});
        chk("read_req_q", 10'h0, {9'h0, read_req_q});
        xfer("data", 8'h3c, 1'b0, 1'b0, 1'b1);
        xfer("data", 8'hc3, 1'b0, 1'b1, 1'b1);
        chk("launch", 10'h1, 10'(launches - l0));
        drain(8'h3c);
        drain(8'hc3);
        chk("data_valid", 10'h0, {9'h0, data_valid});
    endtask

    task automatic s_protect;
        int l0;
        l0 = launches;
        wp <= 1'b1;
        xfer("sel", 8'haa, 1'b1, 1'b0, 1'b1);
        xfer("addr", 8'h00, 1'b0, 1'b0, 1'b1);
        xfer("data", 8'h55, 1'b0, 1'b1, 1'b0);
        chk("launch", 10'h0, 10'(launches - l0));
        chk("data_valid", 10'h0, {9'h0, data_valid});
        wp <= 1'b0;
    endtask

    task automatic s_reject;
        foreach (bad[i]) begin
            xfer("bad sel", bad[i], 1'b1, 1'b0, 1'b0);
            xfer("standby", 8'haa, 1'b0, 1'b1, 1'b0);
        end
    endtask

    task automatic s_id_page;
        int l0;
        l0 = launches;
        strap <= 1'bz;
        xfer("id sel", 8'hb6, 1'b1, 1'b0, 1'b1);
        xfer("id addr", 8'h07, 1'b0, 1'b0, 1'b1);
        chk("id_page_q", 10'h1, {9'h0, id_page_q});
        chk("id loc", 10'h7, {6'h0, addr_q[3:0]});
        chk("lock_req_q", 10'h0, {9'h0, lock_req_q});
        xfer("id sel", 8'hb0, 1'b1, 1'b0, 1'b1);
        xfer("lock addr", 8'h80, 1'b0, 1'b1, 1'b1);
        chk("lock_req_q", 10'h1, {9'h0, lock_req_q});
        chk("launch", 10'h0, 10'(launches - l0));
    endtask

    task automatic s_read;
        strap <= 1'b0;
        xfer("rd sel", 8'ha1, 1'b1, 1'b0, 1'b1);
        chk("read_req_q", 10'h1, {9'h0, read_req_q});
        xfer("rd idle", 8'hff, 1'b0, 1'b1, 1'b0);
    endtask

    task automatic s_busy;
        wbusy <= 1'b1;
        xfer("busy sel", 8'ha0, 1'b1, 1'b1, 1'b0);
        wbusy <= 1'b0;
        xfer("idle sel", 8'ha0, 1'b1, 1'b1, 1'b1);
    endtask

    // ------------------------------------------------------------
    // clock, reset, sequence, watchdog
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    initial begin
        resetn = 1'b0;
        cmd_valid = 1'b0;
        cmd_byte = 8'h00;
        cmd_start = 1'b0;
        cmd_stop = 1'b0;
        strap = 1'b1;
        wp = 1'b0;
        wbusy = 1'b0;
        data_ready = 1'b0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        s_write;
        s_protect;
        s_reject;
        s_id_page;
        s_read;
        s_busy;
        finish_test;
    end

    initial begin
        repeat (30000) @(posedge mclk);
        failures++;
        finish_test;
    end
endmodule // serial_eeprom_i2c_slave_front_test
